// file: plcia_pkg.sv
// constants, register map and types shared by the link control block
// assumes a 100 MHz core clock and a 32-bit classic wishbone register bus
`default_nettype none

package plcia_pkg;

  // clock and fast link down window timing
  localparam int CLK_NS = 10;
  localparam int WIN_US = 10;
  localparam int WIN_CYC = WIN_US * 1000 / CLK_NS;
  localparam int WIN_CNT_W = 10;
  localparam logic [WIN_CNT_W-1:0] WIN_LAST = WIN_CNT_W'(WIN_CYC - 1);

  // event thresholds per window
  localparam int RXER_THR = 32;
  localparam int CODE_THR = 20;
  localparam int SNR_THR = 20;
  localparam int EVT_CNT_W = 6;

  // bus widths and register indices (byte address is four times the index)
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int REG_W = 16;
  localparam logic [5:0] IDX_CTRL3 = 6'h0B;
  localparam logic [5:0] IDX_ACC = 6'h0D;
  localparam logic [5:0] IDX_ADDAT = 6'h0E;
  localparam logic [5:0] IDX_FLDST = 6'h0F;

  // link_control_three fields
  localparam int CTRL3_POL_BIT = 6;
  localparam int CTRL3_SWAP_BIT = 5;
  localparam int CTRL3_DSCR_BIT = 10;
  localparam int FLD_ENERGY = 0;
  localparam int FLD_SNR = 1;
  localparam int FLD_CODE = 2;
  localparam int FLD_RXER = 3;
  localparam int FLD_DSCR = 4;
  localparam logic [15:0] CTRL3_RST = 16'h1000;

  // extended_access_control fields
  localparam int ACC_CMD_LSB = 14;
  localparam int ACC_DEV_LSB = 0;
  localparam logic [15:0] ACC_RW_MASK = 16'hC01F;
  localparam logic [15:0] ACC_RST = 16'h0000;
  localparam logic [15:0] PTR_RST = 16'h0000;

  // fast link down status field position
  localparam int FLDST_LSB = 4;

  // device select codes and address limits
  localparam logic [4:0] DEV_VENDOR = 5'h1F;
  localparam logic [4:0] DEV_MMD3 = 5'h03;
  localparam logic [4:0] DEV_MMD7 = 5'h07;
  localparam logic [15:0] VENDOR_MAX = 16'h04D1;
  localparam int SPACE_AW = 11;
  localparam int MEM_AW = SPACE_AW + 2;
  localparam logic [1:0] SP_VENDOR = 2'h0;
  localparam logic [1:0] SP_MMD3 = 2'h1;
  localparam logic [1:0] SP_MMD7 = 2'h2;

  typedef enum logic [1:0] {
    CMD_ADDR = 2'b00,
    CMD_DATA = 2'b01,
    CMD_INC_RW = 2'b10,
    CMD_INC_W = 2'b11
  } plcia_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_ACK = 2'b10
  } plcia_bus_st_t;

endpackage : plcia_pkg

`default_nettype wire

// file: plcia_mem_if.sv
// port bundle between the access logic and the indirect register memory
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none

interface plcia_mem_if #(
  parameter int AW = 13,
  parameter int DW = 16
);
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic we;

  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface : plcia_mem_if

`default_nettype wire

// file: plcia_mmd_ram.sv
// storage for the registers reached through the indirect data register
// assumes one request per cycle; read data come one cycle after the address
`timescale 1ns/100ps
`default_nettype none

module plcia_mmd_ram #(
  parameter int AW = plcia_pkg::MEM_AW,
  parameter int DW = plcia_pkg::REG_W
) (
  input wire logic i_clk,
  plcia_mem_if.mem port
);
  import plcia_pkg::*;

  logic [DW-1:0] ram [0:(1 << AW) - 1];

  generate
    if (AW < 2 || DW < 1) begin : g_bad
      $error("plcia_mmd_ram: unsupported geometry");
    end
  endgenerate

  // read-first: a write and a read of one word in a cycle return the old word
  always_ff @(posedge i_clk) begin
    if (port.we) begin
      ram[port.addr] <= port.wdata;
    end
    port.rdata <= ram[port.addr];
  end

endmodule : plcia_mmd_ram

`default_nettype wire

// file: plcia_win_cnt.sv
// event counter over a repeating window with a one-cycle threshold pulse
// assumes i_win_start is a one-cycle pulse at the start of each window
`timescale 1ns/100ps
`default_nettype none

module plcia_win_cnt #(
  parameter int THRESH = plcia_pkg::RXER_THR,
  parameter int CW = plcia_pkg::EVT_CNT_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic i_win_start,
  input wire logic i_event,
  output logic o_hit
);
  import plcia_pkg::*;

  typedef struct packed {
    logic [CW-1:0] count;
    logic hit;
  } plcia_cnt_state_t;

  localparam logic [CW-1:0] LAST = CW'(THRESH - 1);

  plcia_cnt_state_t state;
  plcia_cnt_state_t next_state;
  logic [CW-1:0] base;

  generate
    if (THRESH < 1 || THRESH >= (1 << CW)) begin : g_bad
      $error("plcia_win_cnt: threshold does not fit the counter");
    end
  endgenerate

  // count stops at the threshold so a window fires at most once
  always_comb begin
    base = i_win_start ? '0 : state.count;
    next_state = state;
    next_state.count = base;
    next_state.hit = 1'b0;
    if (i_en && i_event && base <= LAST) begin
      next_state.count = base + CW'(1);
      next_state.hit = (base == LAST);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_hit = state.hit;

endmodule : plcia_win_cnt

`default_nettype wire

// file: plcia_top.sv
// link control register bank: pair controls, fast link down, indirect access
// assumes a classic wishbone master and event inputs synchronous to i_clk
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - polarity bit inverts both transmit and receive pairs
// - pair swap bit exchanges transmit and receive pairs
// - both swap bits set enter port mirror
// - 32 receive errors per window drop link
// - 20 line code violations per window drop
// - 20 low SNR crossings per window drop
// - energy loss drops link when enabled
// - link drops on OR of enabled causes
// - fast link down enables reset to zero
// - command selects address or data access style
// - device select steers every indirect access
// - select 11111 reaches vendor space up to 0x04D1
// - select 00011 reaches MMD 3
// - select 00111 reaches MMD 7
// - other device selects are ignored
// - data register shows pointer or selected data
// - descrambler loss drops link when enabled
// - each firing cause latches its status flag
module plcia_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [plcia_pkg::WB_AW-1:0] i_wb_adr,
  input wire logic [plcia_pkg::WB_DW-1:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic o_wb_ack,
  output logic [plcia_pkg::WB_DW-1:0] o_wb_dat,
  input wire logic i_rx_err,
  input wire logic i_code_viol,
  input wire logic i_snr_cross,
  input wire logic i_energy_loss,
  input wire logic i_descr_loss,
  output logic o_tx_pol_inv,
  output logic o_rx_pol_inv,
  output logic o_pair_swap,
  output logic o_port_mirror,
  output logic o_link_drop
);
  import plcia_pkg::*;

  typedef struct packed {
    plcia_bus_st_t st;
    logic [15:0] ctrl3;
    logic [15:0] acc;
    logic [15:0] ptr_vendor;
    logic [15:0] ptr_mmd3;
    logic [15:0] ptr_mmd7;
    logic [4:0] fld_status;
    logic [WIN_CNT_W-1:0] win_cnt;
    logic win_start;
    logic link_drop;
    logic mirror;
    logic [WB_DW-1:0] rdat;
  } plcia_state_t;

  plcia_state_t state;
  plcia_state_t next_state;

  plcia_mem_if #(.AW(MEM_AW), .DW(REG_W)) mem_bus ();

  logic req;
  logic [5:0] idx;
  plcia_cmd_t cmd;
  logic [4:0] dev_sel;
  logic dev_ok;
  logic addr_ok;
  logic data_ok;
  logic [15:0] ptr;
  logic [1:0] space;
  logic run;
  logic wr_data;
  logic rd_data;
  logic bump;
  logic rx_hit;
  logic code_hit;
  logic snr_hit;
  logic [4:0] cause;

  // keeps unselected byte lanes of a 16-bit register
  function automatic logic [15:0] plcia_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0] sel);
    plcia_merge = old_v;
    if (sel[0]) begin
      plcia_merge[7:0] = new_v[7:0];
    end
    if (sel[1]) begin
      plcia_merge[15:8] = new_v[15:8];
    end
  endfunction : plcia_merge

  // request decode and the command and device select fields
  assign req = i_wb_cyc && i_wb_stb;
  assign idx = i_wb_adr[7:2];
  assign cmd = plcia_cmd_t'(state.acc[ACC_CMD_LSB +: 2]);
  assign dev_sel = state.acc[ACC_DEV_LSB +: 5];
  assign run = (state.st == ST_RUN) && req;

  // device select mux; unknown codes reach nothing
  always_comb begin
    dev_ok = 1'b1;
    ptr = state.ptr_vendor;
    space = SP_VENDOR;
    addr_ok = (state.ptr_vendor <= VENDOR_MAX);
    if (dev_sel == DEV_VENDOR) begin
      ptr = state.ptr_vendor;
    end else if (dev_sel == DEV_MMD3) begin
      ptr = state.ptr_mmd3;
      space = SP_MMD3;
      addr_ok = (state.ptr_mmd3[15:SPACE_AW] == '0);
    end else if (dev_sel == DEV_MMD7) begin
      ptr = state.ptr_mmd7;
      space = SP_MMD7;
      addr_ok = (state.ptr_mmd7[15:SPACE_AW] == '0);
    end else begin
      dev_ok = 1'b0;
      addr_ok = 1'b0;
    end
  end

  // data access qualifies only for a known device and an address in range
  assign data_ok = dev_ok && addr_ok && (cmd != CMD_ADDR);
  assign wr_data = run && i_wb_we && (idx == IDX_ADDAT) && data_ok;
  assign rd_data = run && !i_wb_we && (idx == IDX_ADDAT) && data_ok;
  assign bump = (wr_data && (cmd != CMD_DATA)) ||
                (rd_data && (cmd == CMD_INC_RW));

  // memory is read every cycle, so data are ready in the run state
  assign mem_bus.addr = {space, ptr[SPACE_AW-1:0]};
  assign mem_bus.we = wr_data;
  assign mem_bus.wdata = plcia_merge(mem_bus.rdata, i_wb_dat[15:0],
                                     i_wb_sel[1:0]);

  plcia_mmd_ram #(.AW(MEM_AW), .DW(REG_W)) u_ram (
    .i_clk(i_clk),
    .port(mem_bus)
  );

  // windowed event counters
  plcia_win_cnt #(.THRESH(RXER_THR), .CW(EVT_CNT_W)) u_rx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_en(state.ctrl3[FLD_RXER]),
    .i_win_start(state.win_start),
    .i_event(i_rx_err),
    .o_hit(rx_hit)
  );

  plcia_win_cnt #(.THRESH(CODE_THR), .CW(EVT_CNT_W)) u_code (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_en(state.ctrl3[FLD_CODE]),
    .i_win_start(state.win_start),
    .i_event(i_code_viol),
    .o_hit(code_hit)
  );

  plcia_win_cnt #(.THRESH(SNR_THR), .CW(EVT_CNT_W)) u_snr (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_en(state.ctrl3[FLD_SNR]),
    .i_win_start(state.win_start),
    .i_event(i_snr_cross),
    .o_hit(snr_hit)
  );

  // fast link down causes, gated by their enables
  assign cause[FLD_RXER] = rx_hit && state.ctrl3[FLD_RXER];
  assign cause[FLD_CODE] = code_hit && state.ctrl3[FLD_CODE];
  assign cause[FLD_SNR] = snr_hit && state.ctrl3[FLD_SNR];
  assign cause[FLD_ENERGY] = i_energy_loss && state.ctrl3[FLD_ENERGY];
  assign cause[FLD_DSCR] = i_descr_loss && state.ctrl3[CTRL3_DSCR_BIT];

  // next state: bus sequencing, register writes, status and window timing
  always_comb begin
    next_state = state;
    next_state.win_start = (state.win_cnt == WIN_LAST);
    next_state.win_cnt = next_state.win_start ? '0 :
                         state.win_cnt + WIN_CNT_W'(1);
    next_state.link_drop = |cause;
    next_state.fld_status = state.fld_status;
    if (run && !i_wb_we && (idx == IDX_FLDST)) begin
      next_state.fld_status = '0;
    end
    // a cause in the clearing read's cycle still latches
    next_state.fld_status = next_state.fld_status | cause;
    case (state.st)
      ST_IDLE: begin
        if (req) begin
          next_state.st = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state.st = req ? ST_ACK : ST_IDLE;
        next_state.rdat = '0;
        if (idx == IDX_CTRL3) begin
          next_state.rdat[15:0] = state.ctrl3;
        end else if (idx == IDX_ACC) begin
          next_state.rdat[15:0] = state.acc & ACC_RW_MASK;
        end else if (idx == IDX_ADDAT) begin
          if (cmd == CMD_ADDR) begin
            next_state.rdat[15:0] = dev_ok ? ptr : '0;
          end else if (data_ok) begin
            next_state.rdat[15:0] = mem_bus.rdata;
          end
        end else if (idx == IDX_FLDST) begin
          next_state.rdat[15:0] = {7'h00, state.fld_status, 4'h0};
        end
        if (run && i_wb_we) begin
          if (idx == IDX_CTRL3) begin
            next_state.ctrl3 = plcia_merge(state.ctrl3, i_wb_dat[15:0],
                                           i_wb_sel[1:0]);
          end else if (idx == IDX_ACC) begin
            next_state.acc = plcia_merge(state.acc, i_wb_dat[15:0],
                                         i_wb_sel[1:0]) & ACC_RW_MASK;
          end else if (idx == IDX_ADDAT && cmd == CMD_ADDR) begin
            if (dev_sel == DEV_VENDOR) begin
              next_state.ptr_vendor = plcia_merge(ptr, i_wb_dat[15:0],
                                                  i_wb_sel[1:0]);
            end else if (dev_sel == DEV_MMD3) begin
              next_state.ptr_mmd3 = plcia_merge(ptr, i_wb_dat[15:0],
                                                i_wb_sel[1:0]);
            end else if (dev_sel == DEV_MMD7) begin
              next_state.ptr_mmd7 = plcia_merge(ptr, i_wb_dat[15:0],
                                                i_wb_sel[1:0]);
            end
          end
        end
        if (bump) begin
          if (dev_sel == DEV_VENDOR) begin
            next_state.ptr_vendor = ptr + 16'h0001;
          end else if (dev_sel == DEV_MMD3) begin
            next_state.ptr_mmd3 = ptr + 16'h0001;
          end else begin
            next_state.ptr_mmd7 = ptr + 16'h0001;
          end
        end
      end
      ST_ACK: begin
        next_state.st = ST_IDLE;
      end
      default: begin
        next_state.st = ST_IDLE;
      end
    endcase
    next_state.mirror = next_state.ctrl3[CTRL3_POL_BIT] &&
                        next_state.ctrl3[CTRL3_SWAP_BIT];
  end

  // enables clear at reset, so nothing drops the link until set
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= '0;
      state.ctrl3 <= CTRL3_RST;
      state.acc <= ACC_RST;
      state.ptr_vendor <= PTR_RST;
      state.ptr_mmd3 <= PTR_RST;
      state.ptr_mmd7 <= PTR_RST;
    end else begin
      state <= next_state;
    end
  end

  // outputs
  assign o_wb_ack = (state.st == ST_ACK) && req;
  assign o_wb_dat = state.rdat;
  assign o_tx_pol_inv = state.ctrl3[CTRL3_POL_BIT];
  assign o_rx_pol_inv = state.ctrl3[CTRL3_POL_BIT];
  assign o_pair_swap = state.ctrl3[CTRL3_SWAP_BIT];
  assign o_port_mirror = state.mirror;
  assign o_link_drop = state.link_drop;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  pol_write_a: assert property (run && i_wb_we && idx == IDX_CTRL3 &&
    i_wb_sel[0] |=> o_tx_pol_inv == $past(i_wb_dat[6]) &&
    o_rx_pol_inv == $past(i_wb_dat[6]))
    else $error("polarity outputs do not follow the write");
  swap_write_a: assert property (run && i_wb_we && idx == IDX_CTRL3 &&
    i_wb_sel[0] |=> o_pair_swap == $past(i_wb_dat[5]))
    else $error("pair swap output does not follow the write");
  port_mirror_a: assert property (o_port_mirror ==
    (o_tx_pol_inv && o_pair_swap))
    else $error("port mirror disagrees with swap bits");
  rx_drop_a: assert property (rx_hit && state.ctrl3[FLD_RXER]
    |=> o_link_drop && state.fld_status[FLD_RXER])
    else $error("receive error threshold did not drop link");
  energy_drop_a: assert property (i_energy_loss &&
    state.ctrl3[FLD_ENERGY] |=> o_link_drop && state.fld_status[FLD_ENERGY])
    else $error("energy loss did not drop link");
  no_cause_a: assert property (state.ctrl3[3:0] == 4'h0 &&
    !state.ctrl3[CTRL3_DSCR_BIT] |=> !o_link_drop)
    else $error("link dropped with all causes disabled");
  descr_flag_a: assert property (i_descr_loss &&
    state.ctrl3[CTRL3_DSCR_BIT] |=> state.fld_status[FLD_DSCR] ##1
    (state.fld_status[FLD_DSCR] ||
    $past(run && !i_wb_we && idx == IDX_FLDST)))
    else $error("descrambler loss flag not latched");
  reset_modes_a: assert property ($past(i_rst) |->
    state.ctrl3[3:0] == 4'h0 && !o_link_drop)
    else $error("fast link down enables not clear after reset");
  win_space_a: assert property (state.win_start |=>
    !state.win_start [*8])
    else $error("window start pulses too close");
  bus_latency_a: assert property (state.st == ST_IDLE && req |=>
    !o_wb_ack ##1 o_wb_ack)
    else $error("bus answer not two cycles after request");
  ptr_read_a: assert property (run && !i_wb_we &&
    idx == IDX_ADDAT && cmd == CMD_ADDR && dev_sel == DEV_MMD7
    |=> o_wb_dat[15:0] == state.ptr_mmd7)
    else $error("pointer read returns wrong value");
  inc_write_a: assert property (wr_data && cmd == CMD_INC_W &&
    dev_sel == DEV_MMD3 |=> state.ptr_mmd3 == $past(state.ptr_mmd3) + 16'h0001)
    else $error("pointer not advanced after write");
  bad_dev_a: assert property (run && idx == IDX_ADDAT && !dev_ok
    |-> !mem_bus.we ##1 $stable(state.ptr_vendor) && $stable(state.ptr_mmd3)
    && $stable(state.ptr_mmd7))
    else $error("access with unknown device select took effect");
  vendor_range_a: assert property (run && !i_wb_we &&
    idx == IDX_ADDAT && cmd != CMD_ADDR && dev_sel == DEV_VENDOR &&
    state.ptr_vendor > VENDOR_MAX |=> o_wb_dat == '0 &&
    $stable(state.ptr_vendor))
    else $error("vendor data access beyond its range");

  mirror_c: cover property (!o_port_mirror ##1 o_port_mirror);
  drop_c: cover property (rx_hit ##1 o_link_drop);
  inc_c: cover property (bump && cmd == CMD_INC_RW);
  clr_c: cover property (state.fld_status != 5'h00 ##[1:20]
    state.fld_status == 5'h00);

endmodule : plcia_top

`default_nettype wire

// file: plcia_host.sv
// classic wishbone master standing in for the station management host
// assumes the slave answers each request within a few tens of cycles
`timescale 1ns/100ps
`default_nettype none

module plcia_host (
  input wire logic i_clk,
  input wire logic i_ack,
  input wire logic [31:0] i_dat,
  output logic o_cyc,
  output logic o_stb,
  output logic o_we,
  output logic [7:0] o_adr,
  output logic [31:0] o_dat,
  output logic [3:0] o_sel
);
  // bus idle from time zero so the slave never sees a stray request
  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we = 1'b0;
    o_adr = 8'h00;
    o_dat = 32'h0000_0000;
    o_sel = 4'h0;
  end

  // one classic cycle; ack and read data are taken at the rising edge
  // where ack is seen high, before that edge's register updates land
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [15:0] wd, output logic [15:0] rd,
                      output logic hung);
    int n;
    n = 0;
    hung = 1'b1;
    rd = 16'h0000;
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we <= we;
    o_adr <= adr;
    o_dat <= {16'h0000, wd};
    o_sel <= 4'hF;
    while (n < 40 && hung) begin
      @(posedge i_clk);
      n++;
      if (i_ack === 1'b1) begin
        rd = i_dat[15:0];
        hung = 1'b0;
      end
    end
    // release at the edge that took the answer, or after giving up
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_we <= 1'b0;
  endtask : xfer
endmodule : plcia_host

`default_nettype wire

// file: plcia_top_tb.sv
// self-checking bench for the link control register bank
// assumes the host model in plcia_host.sv and a 100 MHz clock
`timescale 1ns/100ps
`default_nettype none

module plcia_top_tb;
  import plcia_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [4:0] ev = 5'h00;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic tx_pol, rx_pol, swap, mirror, drop;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_drop = 0;
  int d0, hi, lo;
  logic [15:0] en;

  plcia_host host (.i_clk(i_clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc),
    .o_stb(stb), .o_we(we), .o_adr(adr), .o_dat(wdat), .o_sel(sel));

  // event map: 0 energy, 1 snr, 2 code, 3 rx error, 4 descrambler
  plcia_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(sel), .o_wb_ack(ack), .o_wb_dat(rdat), .i_rx_err(ev[3]),
    .i_code_viol(ev[2]), .i_snr_cross(ev[1]), .i_energy_loss(ev[0]),
    .i_descr_loss(ev[4]), .o_tx_pol_inv(tx_pol), .o_rx_pol_inv(rx_pol),
    .o_pair_swap(swap), .o_port_mirror(mirror), .o_link_drop(drop));

  always #5 i_clk = ~i_clk;

  // count drop cycles so tests compare counts, not a racing flag
  always @(posedge i_clk) begin
    if (drop === 1'b1) n_drop <= n_drop + 1;
  end

  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t word %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    logic hung;
    host.xfer(w, a, d, q, hung);
    if (hung) begin
      n_mismatch++;
      $display("[FAIL] t=%0t bus answer missing", $time);
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    xfer(1'b0, a, 16'h0000, q);
    chk16(q, exp);
  endtask : rd

  // command and device select in one write of the access control word
  task automatic acc(input logic [1:0] cmd, input logic [4:0] dev);
    wr(8'h34, {cmd, 9'h000, dev});
  endtask : acc

  // n consecutive event cycles, then time for a drop to show
  task automatic fire(input int k, input int n);
    repeat (n) begin
      @(posedge i_clk);
      ev[k] <= 1'b1;
    end
    @(posedge i_clk);
    ev[k] <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask : fire

  // a hang ends the run through the same closing task
  initial begin
    #300000;
    n_mismatch++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'h2C, 16'h1000);
    rd(8'h34, 16'h0000);
    rd(8'h3C, 16'h0000);
    chk1(drop, 1'b0);
    wr(8'h34, 16'hFFFF);
    rd(8'h34, 16'hC01F);
    wr(8'h3C, 16'hFFFF);
    rd(8'h3C, 16'h0000);
    rd(8'h00, 16'h0000);
    // every combination of the two pair controls
    for (int v = 0; v < 4; v++) begin
      wr(8'h2C, 16'h1000 | 16'(v << 5));
      repeat (2) @(posedge i_clk);
      chk1(tx_pol, v[1]);
      chk1(rx_pol, v[1]);
      chk1(swap, v[0]);
      chk1(mirror, v[1] & v[0]);
    end
    // indirect access: the three legal selects, then the unknown select 00001
    acc(2'b00, DEV_MMD3);
    wr(8'h38, 16'h0005);
    acc(2'b01, DEV_MMD3);
    wr(8'h38, 16'hAAAA);
    rd(8'h38, 16'hAAAA);
    acc(2'b00, DEV_MMD3);
    rd(8'h38, 16'h0005);
    acc(2'b10, DEV_MMD3);
    rd(8'h38, 16'hAAAA);
    acc(2'b00, DEV_MMD3);
    rd(8'h38, 16'h0006);
    acc(2'b11, DEV_MMD3);
    wr(8'h38, 16'hBBBB);
    acc(2'b00, DEV_MMD3);
    rd(8'h38, 16'h0007);
    wr(8'h38, 16'h0006);
    acc(2'b11, DEV_MMD3);
    rd(8'h38, 16'hBBBB);
    acc(2'b00, DEV_MMD3);
    rd(8'h38, 16'h0006);
    acc(2'b00, DEV_MMD7);
    wr(8'h38, 16'h0005);
    acc(2'b01, DEV_MMD7);
    wr(8'h38, 16'hCCCC);
    rd(8'h38, 16'hCCCC);
    acc(2'b00, DEV_MMD7);
    rd(8'h38, 16'h0005);
    acc(2'b01, DEV_MMD3);
    rd(8'h38, 16'hBBBB);
    acc(2'b00, DEV_VENDOR);
    wr(8'h38, VENDOR_MAX);
    acc(2'b01, DEV_VENDOR);
    wr(8'h38, 16'h1234);
    rd(8'h38, 16'h1234);
    acc(2'b00, DEV_VENDOR);
    wr(8'h38, VENDOR_MAX + 16'h0001);
    acc(2'b01, DEV_VENDOR);
    rd(8'h38, 16'h0000);
    acc(2'b00, 5'h01);
    wr(8'h38, 16'h0005);
    rd(8'h38, 16'h0000);
    // the ignored write must not have reached the vendor or MMD 3 pointer
    acc(2'b00, DEV_VENDOR);
    rd(8'h38, VENDOR_MAX + 16'h0001);
    acc(2'b00, DEV_MMD3);
    rd(8'h38, 16'h0006);
    // each fast link down cause: disabled, below threshold, at twice the threshold (four event cycles for energy and descrambler)
    for (int k = 0; k < 5; k++) begin
      en = (k == 4) ? 16'h0400 : 16'h0001 << k;
      hi = (k == 3) ? 64 : (k == 0 || k == 4) ? 4 : 40;
      lo = (k == 3) ? 31 : (k == 0 || k == 4) ? 0 : 19;
      d0 = n_drop;
      fire(k, hi);
      chk1(n_drop != d0, 1'b0);
      wr(8'h2C, en);
      d0 = n_drop;
      fire(k, lo);
      chk1(n_drop != d0, 1'b0);
      d0 = n_drop;
      fire(k, hi);
      chk1(n_drop != d0, 1'b1);
      rd(8'h3C, 16'h0010 << k);
      rd(8'h3C, 16'h0000);
      wr(8'h2C, 16'h0000);
    end
    // two bursts a full window apart must never add up
    wr(8'h2C, 16'h0002);
    d0 = n_drop;
    fire(1, 19);
    repeat (1000) @(posedge i_clk);
    fire(1, 19);
    chk1(n_drop != d0, 1'b0);
    // a reset in mid-run must bring the control and access registers back to their start
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'h2C, 16'h1000);
    rd(8'h34, 16'h0000);
    chk1(drop, 1'b0);
    tally_and_finish();
  end
endmodule : plcia_top_tb

`default_nettype wire
